// ==== verilog/omc_mode_ctrl.sv ====
// operating mode controller state machine
// Overview of operation
// - missing or low supply keeps the device not powered, interfaces off
// - removing supply forces not-powered mode from any mode
// - idle mode selects the 32 kHz core reference
// - active mode selects the 26 MHz core reference
// - connected mode enables radio data and keeps the 26 MHz reference
// - applying supply enters active mode; alarm cannot start from not powered
// - dedicated-pin variant ignores power-on, restart and alarm while unpowered
// - valid power-off event in active mode shuts down into power-off mode
// - mini-card variant halts instead of entering power-off mode
// - power-on, restart or alarm switches power-off mode into active mode
// - power saving is off after start-up until host writes a setting
// - with power saving on, idle is entered from active when nothing busy
// - flow control on, setting 1 or 3: CTS shows serial port enabled
// - flow control off: CTS held on permanently
// - paging, usb remote wake and periodic serial enable wake from idle
// - flow control off and saving on: serial receive data wakes idle
// - flow control off, setting 2: host RTS on wakes the device
// - setting 3: host DTR on wakes the device out of idle
// - card interface wake or preset alarm also wakes idle
// - connection start or needed radio activity moves active to connected
// - no traffic suspends connected to active, then idle if saving on
// - ending a data connection returns connected to active
`timescale 1ns/1ns
`include "omc_defines.svh"
module omc_mode_ctrl (
  input wire logic clk,
  input wire logic resetn,
  input wire omc_pkg::omc_power_t power,
  input wire omc_pkg::omc_wake_t wake,
  input wire omc_pkg::omc_radio_t radio,
  input wire logic psvWrite,
  input wire logic [1:0] psvValue,
  input wire logic haltCommand,
  input wire logic hwFlowCtrl,
  output omc_pkg::omc_mode_t mode,
  output logic powerSavingOn,
  output logic coreClk32k,
  output logic coreClk26m,
  output logic rfEnable,
  output logic interfacesOn,
  output logic ctsOn
);
  import omc_pkg::*;

  omc_state_t st_r;
  omc_state_t st_nxt;
  logic wakeReq;
  logic switchOn;

  function automatic logic isRunning(input omc_mode_t m);
    return (m == OMC_ACTIVE) || (m == OMC_CONN) || (m == OMC_IDLE);
  endfunction

  always_comb begin
    wakeReq = 1'b0;
    if (wake.pagingTick || wake.usbRemoteWake)
      wakeReq = 1'b1;
    if (wake.uartPeriodicTick && st_r.psv == `OMC_PSV_PERIODIC)
      wakeReq = 1'b1;
    if (!hwFlowCtrl && st_r.psvEnabled && wake.uartRxData)
      wakeReq = 1'b1;
    if (!hwFlowCtrl && st_r.psv == `OMC_PSV_RTS && wake.rtsOn)
      wakeReq = 1'b1;
    if (st_r.psv == `OMC_PSV_DTR && wake.dtrOn)
      wakeReq = 1'b1;
    if (wake.cardWake || wake.alarm)
      wakeReq = 1'b1;
    switchOn = power.powerOnInput || power.restartInput || wake.alarm;
  end

  always_comb begin
    st_nxt = st_r;
    if (!power.supplyOk) begin
      st_nxt.mode = OMC_NOPWR;
      st_nxt.psv = `OMC_PSV_OFF;
      st_nxt.psvEnabled = 1'b0;
      st_nxt.connOpen = 1'b0;
      st_nxt.shutCnt = 8'h00;
    end else begin
      if (psvWrite && isRunning(st_r.mode)) begin
        st_nxt.psv = psvValue;
        st_nxt.psvEnabled = (psvValue != `OMC_PSV_OFF);
      end
      unique case (st_r.mode)
        OMC_NOPWR: begin
          // supply alone starts it; pins and alarm are ignored
          st_nxt.mode = OMC_ACTIVE;
          st_nxt.psv = `OMC_PSV_OFF;
          st_nxt.psvEnabled = 1'b0;
        end
        OMC_OFF: begin
          if (switchOn) begin
            st_nxt.mode = OMC_ACTIVE;
            st_nxt.psv = `OMC_PSV_OFF;
            st_nxt.psvEnabled = 1'b0;
          end
        end
        OMC_ACTIVE: begin
          if (power.powerOffEvent || (haltCommand && power.miniCard)) begin
            st_nxt.mode = OMC_SHUT;
            st_nxt.shutCnt = `OMC_SHUT_CYCLES;
          end else if (radio.connStart || (st_r.connOpen && radio.rfNeeded)) begin
            st_nxt.mode = OMC_CONN;
            if (radio.connStart)
              st_nxt.connOpen = 1'b1;
          end else if (st_r.psvEnabled && !radio.activityBusy && !wakeReq) begin
            st_nxt.mode = OMC_IDLE;
          end
        end
        OMC_CONN: begin
          if (radio.connEnd) begin
            st_nxt.mode = OMC_ACTIVE;
            st_nxt.connOpen = 1'b0;
          end else if (!radio.txRxBusy) begin
            st_nxt.mode = OMC_ACTIVE;
          end
        end
        OMC_IDLE: begin
          if (wakeReq || (st_r.connOpen && radio.rfNeeded))
            st_nxt.mode = OMC_ACTIVE;
        end
        OMC_SHUT: begin
          if (st_r.shutCnt > 8'h01) begin
            st_nxt.shutCnt = st_r.shutCnt - 8'h01;
          end else begin
            st_nxt.mode = power.miniCard ? OMC_HALT : OMC_OFF;
            st_nxt.shutCnt = 8'h00;
            st_nxt.connOpen = 1'b0;
          end
        end
        OMC_HALT: begin
          // halt leaves only through restart input or supply loss
          if (power.restartInput) begin
            st_nxt.mode = OMC_ACTIVE;
            st_nxt.psv = `OMC_PSV_OFF;
            st_nxt.psvEnabled = 1'b0;
          end
        end
        default: st_nxt.mode = OMC_NOPWR;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '{mode: OMC_NOPWR, psv: 2'h0, psvEnabled: 1'b0, shutCnt: 8'h00,
                connOpen: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    mode = st_r.mode;
    powerSavingOn = st_r.psvEnabled;
    coreClk32k = (st_r.mode == OMC_IDLE);
    coreClk26m = (st_r.mode == OMC_ACTIVE) || (st_r.mode == OMC_CONN);
    rfEnable = (st_r.mode == OMC_CONN);
    interfacesOn = coreClk26m;
    if (!hwFlowCtrl)
      ctsOn = 1'b1;
    else if (st_r.psv == `OMC_PSV_PERIODIC || st_r.psv == `OMC_PSV_DTR)
      ctsOn = interfacesOn;
    else
      ctsOn = interfacesOn;
  end
endmodule

// ==== pkg/omc_defines.svh ====
// constants for the operating mode controller
`ifndef OMC_DEFINES_SVH
`define OMC_DEFINES_SVH
`define OMC_PSV_OFF 2'h0
`define OMC_PSV_PERIODIC 2'h1
`define OMC_PSV_RTS 2'h2
`define OMC_PSV_DTR 2'h3
`define OMC_SHUT_CYCLES 8'h04
`endif

// ==== pkg/omc_pkg.sv ====
// types for the operating mode controller
package omc_pkg;
  typedef enum logic [2:0] {
    OMC_NOPWR = 3'h0,
    OMC_OFF = 3'h1,
    OMC_ACTIVE = 3'h3,
    OMC_CONN = 3'h2,
    OMC_IDLE = 3'h6,
    OMC_SHUT = 3'h7,
    OMC_HALT = 3'h5
  } omc_mode_t;

  typedef struct packed {
    logic usbRemoteWake;
    logic pagingTick;
    logic uartPeriodicTick;
    logic uartRxData;
    logic rtsOn;
    logic dtrOn;
    logic cardWake;
    logic alarm;
  } omc_wake_t;

  typedef struct packed {
    logic supplyOk;
    logic powerOnInput;
    logic restartInput;
    logic powerOffEvent;
    logic miniCard;
    logic dedicatedPins;
  } omc_power_t;

  typedef struct packed {
    logic connStart;
    logic rfNeeded;
    logic txRxBusy;
    logic connEnd;
    logic activityBusy;
  } omc_radio_t;

  typedef struct packed {
    omc_mode_t mode;
    logic [1:0] psv;
    logic psvEnabled;
    logic [7:0] shutCnt;
    logic connOpen;
  } omc_state_t;
endpackage

// ==== sim/omc_host_model.sv ====
// host processor model driving the serial wake lines
`timescale 1ns/1ns
module omc_host_model (
  input wire logic clk,
  input wire logic [1:0] req,
  output logic rtsOn = 1'b0,
  output logic dtrOn = 1'b0
);
  always @(posedge clk) begin
    rtsOn <= req[1];
    dtrOn <= req[0];
  end
endmodule

// ==== sim/omc_mode_ctrl_monitor.sv ====
// port checker for the mode controller
`timescale 1ns/1ns
module omc_mode_ctrl_monitor (
  input wire logic clk,
  input wire logic resetn,
  input wire omc_pkg::omc_power_t power,
  input wire omc_pkg::omc_wake_t wake,
  input wire logic hwFlowCtrl,
  input wire omc_pkg::omc_mode_t mode,
  input wire logic coreClk32k,
  input wire logic coreClk26m,
  input wire logic rfEnable,
  input wire logic ctsOn
);
  import omc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_loss_nopwr: assert property (!power.supplyOk |=> mode == OMC_NOPWR)
    else $error("supply loss kept mode");
  a_idle_slow: assert property (coreClk32k == (mode == OMC_IDLE))
    else $error("slow clock wrong");
  a_run_fast: assert property (coreClk26m == (mode inside {OMC_ACTIVE, OMC_CONN}))
    else $error("fast clock wrong");
  a_conn_rf: assert property (rfEnable == (mode == OMC_CONN))
    else $error("radio enable wrong");
  a_cts_fixed: assert property (!hwFlowCtrl |-> ctsOn)
    else $error("cts not on");
  a_supply_start: assert property (mode == OMC_NOPWR && power.supplyOk |=> mode == OMC_ACTIVE)
    else $error("no start on supply");
  a_off_wake: assert property (mode == OMC_OFF && power.supplyOk && (power.powerOnInput
    || power.restartInput || wake.alarm) |=> mode == OMC_ACTIVE)
    else $error("no switch on");
  a_idle_wake: assert property (mode == OMC_IDLE && power.supplyOk && (wake.pagingTick
    || wake.usbRemoteWake || wake.cardWake || wake.alarm) |=> mode == OMC_ACTIVE)
    else $error("idle did not wake");
endmodule
bind omc_mode_ctrl omc_mode_ctrl_monitor mon (.clk(clk), .resetn(resetn), .power(power),
  .wake(wake), .hwFlowCtrl(hwFlowCtrl), .mode(mode), .coreClk32k(coreClk32k),
  .coreClk26m(coreClk26m), .rfEnable(rfEnable), .ctsOn(ctsOn));

// ==== sim/omc_mode_ctrl_tb.sv ====
// bench for the operating mode controller
`timescale 1ns/1ns
module omc_mode_ctrl_tb;
  import omc_pkg::*;
  logic clk = 0, resetn = 0, psvWrite = 0, haltCommand = 0, hwFlowCtrl = 1;
  logic [1:0] psvValue = 2'h0, hostReq = 2'h0;
  logic [1:0] ps [8] = '{2'h1, 2'h1, 2'h3, 2'h2, 2'h1, 2'h1, 2'h1, 2'h1};
  logic [5:0] pon [3] = '{6'h30, 6'h28, 6'h20};
  omc_power_t pw = 6'h19;
  omc_wake_t wk = 8'h01;
  omc_wake_t wake;
  omc_radio_t rd = 5'h00;
  omc_mode_t mode;
  logic psOn, c32, c26, rfOn, ifOn, cts, rtsOn, dtrOn;
  int mismatches = 0, samples_checked = 0, i;
  initial forever #50 clk = ~clk;
  omc_host_model host (.clk(clk), .req(hostReq), .rtsOn(rtsOn), .dtrOn(dtrOn));
  assign wake = {wk[7:4], rtsOn, dtrOn, wk[1:0]};
  omc_mode_ctrl dut (.clk(clk), .resetn(resetn), .power(pw), .wake(wake), .radio(rd),
    .psvWrite(psvWrite), .psvValue(psvValue), .haltCommand(haltCommand),
    .hwFlowCtrl(hwFlowCtrl), .mode(mode), .powerSavingOn(psOn), .coreClk32k(c32),
    .coreClk26m(c26), .rfEnable(rfOn), .interfacesOn(ifOn), .ctsOn(cts));
  task automatic chk(input string n, input logic [2:0] s, e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic go(int n);
    repeat (n) @(posedge clk);
  endtask
  // bounded wait, edges only after negedge sampling
  task automatic waitMode(omc_mode_t m);
    for (int k = 0; k < 50 && mode !== m; k++) @(negedge clk);
    if (mode !== m) begin
      mismatches++;
      test_done();
    end
  endtask
  initial begin
    go(8);
    resetn <= 1;
    go(3);
    @(negedge clk);
    chk("pins", mode, OMC_NOPWR);
    chk("ifc", ifOn, 3'h0);
    go(1);
    pw <= 6'h20;
    hwFlowCtrl <= 0;
    wk <= '0;
    go(1);
    @(negedge clk);
    chk("start", mode, OMC_ACTIVE);
    chk("clk", {c26, c32}, 3'h2);
    chk("psv", psOn, 3'h0);
    // every wake source, each under the setting it needs
    for (i = 0; i < 8; i++) begin
      go(1);
      psvWrite <= 1;
      psvValue <= ps[i];
      go(1);
      psvWrite <= 0;
      waitMode(OMC_IDLE);
      chk("idle", {c32, c26, cts}, 3'h5);
      go(1);
      wk <= (8'h01 << i) & 8'hf3;
      hostReq <= {i == 3, i == 2};
      go(2);
      @(negedge clk);
      chk("wake", mode, OMC_ACTIVE);
      go(1);
      wk <= '0;
      hostReq <= 2'h0;
    end
    hwFlowCtrl <= 1;
    waitMode(OMC_IDLE);
    chk("cts", cts, 3'h0);
    go(1);
    wk <= 8'h40;
    rd <= 5'h01;
    go(1);
    wk <= '0;
    waitMode(OMC_ACTIVE);
    go(1);
    rd <= 5'h15;
    go(1);
    @(negedge clk);
    chk("conn", mode, OMC_CONN);
    chk("rf", {2'h0, rfOn}, 3'h1);
    go(1);
    rd <= 5'h01;
    go(1);
    @(negedge clk);
    chk("susp", mode, OMC_ACTIVE);
    go(1);
    rd <= 5'h0d;
    go(1);
    @(negedge clk);
    chk("resume", mode, OMC_CONN);
    go(1);
    rd <= 5'h07;
    go(1);
    @(negedge clk);
    chk("end", mode, OMC_ACTIVE);
    rd <= 5'h01;
    // shutdown, then each switch-on cause
    for (i = 0; i < 3; i++) begin
      go(1);
      pw <= 6'h24;
      go(1);
      pw <= 6'h20;
      go(3);
      @(negedge clk);
      chk("shut", mode, OMC_SHUT);
      go(1);
      @(negedge clk);
      chk("off", mode, OMC_OFF);
      chk("offifc", {2'h0, ifOn}, 3'h0);
      go(1);
      pw <= pon[i];
      wk <= {7'h0, i == 2};
      go(1);
      pw <= 6'h20;
      wk <= '0;
      @(negedge clk);
      chk("on", mode, OMC_ACTIVE);
      chk("onifc", {2'h0, ifOn}, 3'h1);
    end
    go(1);
    pw <= 6'h22;
    haltCommand <= 1;
    go(1);
    haltCommand <= 0;
    waitMode(OMC_HALT);
    chk("halt", mode, OMC_HALT);
    go(1);
    pw <= 6'h00;
    go(1);
    @(negedge clk);
    chk("loss", mode, OMC_NOPWR);
    test_done();
  end
endmodule
